// file: modem_far_end.sv
// Behavioural far-end modem that drives the active-low clear-to-send line
module modem_far_end (
    // Clock
    input wire logic clk_sys,
    // Readiness and response speed
    input wire logic ready,
    input wire logic slow,
    // Line to the port
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] lag_reg = 4'h0;
    // A slow data set reports its readiness four cycles late
    always @(posedge clk_sys) lag_reg <= {lag_reg[2:0], ready};
    // Line is low while ready (while ready four cycles earlier when slow) and high otherwise
    assign cts_n = !(slow ? lag_reg[3] : ready);
endmodule

// file: tb.sv
// Self-checking bench for the receive status flags, clear-to-send status and spare byte
`include "uart_rx_status_params.svh"
module tb
    import uart_rx_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, fifo_mode, fifo_full, fifo_empty, rx_data_available;
    logic loopback_en, rts_ctrl, cts_n, ready, slow;
    reg_req_s bus_req;
    logic [15:0] bus_rdata;
    rx_char_s rx_char, fifo_push;
    logic [7:0] push_data;
    int fail_count = 0, samples_checked = 0, push_cnt = 0;

    uart_rx_status_modem_flags dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .rx_char(rx_char), .fifo_mode(fifo_mode),
        .fifo_full(fifo_full), .fifo_empty(fifo_empty), .fifo_push(fifo_push),
        .rx_data_available(rx_data_available), .loopback_en(loopback_en),
        .rts_ctrl(rts_ctrl), .cts_n(cts_n));
    modem_far_end far (.clk_sys(clk_sys), .ready(ready), .slow(slow), .cts_n(cts_n));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Counts pushes so a late or early pulse is still seen
    always @(posedge clk_sys) begin
        if (fifo_push.valid === 1'b1) begin
            push_cnt <= push_cnt + 1;
            push_data <= fifo_push.data;
        end
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [31:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        #1 chk(name, exp, bus_rdata);
    endtask

    task automatic send(input logic [7:0] d);
        @(posedge clk_sys);
        rx_char <= '{valid: 1'b1, data: d};
        @(posedge clk_sys);
        rx_char.valid <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        wrap_up;
    end

    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        rx_char = '0;
        {fifo_mode, fifo_full, fifo_empty, loopback_en, rts_ctrl, slow} = 6'h08;
        ready = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd_chk("line_status", `ADDR_LINE_STATUS, 16'h0000);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0010);
        rd_chk("spare", `ADDR_SPARE_STORAGE, 16'h0000);
        wr_reg(`ADDR_SPARE_STORAGE, 16'hFFA5);
        rd_chk("spare", `ADDR_SPARE_STORAGE, 16'h00A5);
        wr_reg(`ADDR_MODEM_STATUS, 16'hFFEF);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0010);
        rd_chk("unmapped", 32'h5000_1004, 16'h0000);
        send(8'h11);
        chk("data_available", 16'h0001, 16'(rx_data_available));
        send(8'h22);
        rd_chk("line_status", `ADDR_LINE_STATUS, 16'h0003);
        rd_chk("line_status", `ADDR_LINE_STATUS, 16'h0001);
        rd_chk("rx_buffer", `ADDR_RX_BUFFER, 16'h0022);
        chk("data_available", 16'h0000, 16'(rx_data_available));
        @(posedge clk_sys);
        fifo_mode <= 1'b1;
        fifo_full <= 1'b1;
        send(8'h33);
        chk("push_count", 16'h0000, 16'(push_cnt));
        rd_chk("line_status", `ADDR_LINE_STATUS, 16'h0002);
        @(posedge clk_sys);
        fifo_full <= 1'b0;
        fifo_empty <= 1'b0;
        send(8'h44);
        chk("push_count", 16'h0001, 16'(push_cnt));
        chk("push_data", 16'h0044, {8'h00, push_data});
        chk("data_available", 16'h0001, 16'(rx_data_available));
        @(posedge clk_sys);
        fifo_empty <= 1'b1;
        #1 chk("data_available", 16'h0000, 16'(rx_data_available));
        ready <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0000);
        slow <= 1'b1;
        ready <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0010);
        ready <= 1'b0;
        loopback_en <= 1'b1;
        rts_ctrl <= 1'b1;
        repeat (8) @(posedge clk_sys);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0010);
        ready <= 1'b1;
        rts_ctrl <= 1'b0;
        repeat (8) @(posedge clk_sys);
        rd_chk("modem_status", `ADDR_MODEM_STATUS, 16'h0000);
        wrap_up;
    end
endmodule

// file: uart_rx_status_modem_flags.sv
// Receive status flags, clear-to-send status and spare storage byte of the serial port
// How it works
// - Non-FIFO: char arriving before buffer read sets overrun and overwrites buffer.
// - FIFO: char arriving with FIFO full sets overrun; char is dropped.
// - Reading line status clears overrun; otherwise it sticks; zero after reset.
// - Data-available is high while a character waits in buffer or FIFO.
// - Cleared by buffer read in non-FIFO mode, by FIFO empty in FIFO mode.
// - Clear-to-send status is inverse of cts_n pin; reads 1 after reset.
// - In loopback the clear-to-send status follows the request-to-send bit.
// - Eight-bit spare storage byte, read/write, resets to zero, no side effect.
`include "uart_rx_status_params.svh"

module uart_rx_status_modem_flags
    import uart_rx_status_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire reg_req_s bus_req,
    output logic [15:0] bus_rdata,
    // Receiver shift register and FIFO
    input wire rx_char_s rx_char,
    input wire logic fifo_mode,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    output rx_char_s fifo_push,
    output logic rx_data_available,
    // Modem control and pin
    input wire logic loopback_en,
    input wire logic rts_ctrl,
    input wire logic cts_n
);

    function automatic reg_sel_e decode(input logic [31:0] a);
        reg_sel_e s;
        s = SEL_NONE;
        case (a)
            `ADDR_RX_BUFFER: s = SEL_RXBUF;
            `ADDR_LINE_STATUS: s = SEL_LINE;
            `ADDR_MODEM_STATUS: s = SEL_MODEM;
            `ADDR_SPARE_STORAGE: s = SEL_SPARE;
            default: s = SEL_NONE;
        endcase
        return s;
    endfunction

    reg_sel_e sel_rd;
    reg_sel_e sel_wr;
    logic rd_line;
    logic rd_rxbuf;
    logic ovr_event;
    logic cts_status;

    logic [7:0] rx_buffer_reg;
    logic ready_reg;
    logic overrun_reg;
    logic [7:0] spare_reg;
    logic cts_meta_reg;
    logic cts_sync_reg;

    always_comb begin
        sel_rd = bus_req.rd ? decode(bus_req.addr) : SEL_NONE;
        sel_wr = bus_req.wr ? decode(bus_req.addr) : SEL_NONE;
    end

    assign rd_line = (sel_rd == SEL_LINE);
    assign rd_rxbuf = (sel_rd == SEL_RXBUF);

    // A read in the same cycle as an arrival empties the buffer first, so no overrun
    assign ovr_event = rx_char.valid &&
        (fifo_mode ? fifo_full : (ready_reg && !rd_rxbuf));

    // Receive holding buffer, used only in non-FIFO mode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_buffer_reg <= `RX_BUFFER_RESET;
        end else if (rx_char.valid && !fifo_mode) begin
            rx_buffer_reg <= rx_char.data;
        end
    end

    // Character waiting in the holding buffer; arrival wins over a buffer read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ready_reg <= 1'b0;
        end else if (rx_char.valid && !fifo_mode) begin
            ready_reg <= 1'b1;
        end else if (rd_rxbuf || fifo_mode) begin
            ready_reg <= 1'b0;
        end
    end

    assign rx_data_available = fifo_mode ? !fifo_empty : ready_reg;

    // Sticky overrun; a new overrun wins over the clearing read
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            overrun_reg <= 1'b0;
        end else if (ovr_event) begin
            overrun_reg <= 1'b1;
        end else if (rd_line) begin
            overrun_reg <= 1'b0;
        end
    end

    // Push is registered; the FIFO must count it before the next character arrives
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            fifo_push <= '0;
        end else begin
            fifo_push.valid <= rx_char.valid && fifo_mode && !fifo_full;
            fifo_push.data <= rx_char.data;
        end
    end

    // Pin synchroniser; reset to asserted so the status bit reads 1
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cts_meta_reg <= `CTS_N_SYNC_RESET;
            cts_sync_reg <= `CTS_N_SYNC_RESET;
        end else begin
            cts_meta_reg <= cts_n;
            cts_sync_reg <= cts_meta_reg;
        end
    end

    assign cts_status = loopback_en ? rts_ctrl : !cts_sync_reg;

    // Spare storage byte, no effect on the port
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            spare_reg <= `SPARE_RESET;
        end else if (sel_wr == SEL_SPARE) begin
            spare_reg <= bus_req.wdata[`SPARE_MSB:0];
        end
    end

    // Read data stand for one cycle only; unmapped reads return zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_rdata <= `RDATA_IDLE;
        end else begin
            bus_rdata <= `RDATA_IDLE;
            unique case (sel_rd)
                SEL_NONE: bus_rdata <= `RDATA_IDLE;
                SEL_RXBUF: bus_rdata[7:0] <= rx_buffer_reg;
                SEL_LINE: begin
                    bus_rdata[`LINE_DA_BIT] <= rx_data_available;
                    bus_rdata[`LINE_OVR_BIT] <= overrun_reg;
                end
                SEL_MODEM: bus_rdata[`MODEM_CTS_BIT] <= cts_status;
                SEL_SPARE: bus_rdata[`SPARE_MSB:0] <= spare_reg;
                default: bus_rdata <= `RDATA_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_ovr_nonfifo_set: assert property (
        rx_char.valid && !fifo_mode && ready_reg && !rd_rxbuf |=> overrun_reg)
        else $error("overrun not set on buffer overwrite");

    a_buf_new_char: assert property (
        rx_char.valid && !fifo_mode |=> rx_buffer_reg == $past(rx_char.data)
            && ready_reg)
        else $error("holding buffer not replaced by new character");

    a_ovr_fifo_full: assert property (
        rx_char.valid && fifo_mode && fifo_full |=> overrun_reg && !fifo_push.valid)
        else $error("full FIFO overrun not flagged or character pushed");

    a_ovr_read_clear: assert property (
        rd_line && !ovr_event |=> !overrun_reg)
        else $error("line status read did not clear overrun");

    a_ovr_sticky: assert property (
        overrun_reg && !rd_line |=> overrun_reg)
        else $error("overrun dropped without a read");

    a_da_fifo_view: assert property (
        rd_line && fifo_mode |=> bus_rdata[`LINE_DA_BIT] == !$past(fifo_empty))
        else $error("data available does not match FIFO level");

    a_da_buf_read: assert property (
        !fifo_mode && rd_rxbuf && !rx_char.valid ##1 !fifo_mode |-> !rx_data_available)
        else $error("buffer read did not clear data available");

    a_cts_pin_inv: assert property (
        (!loopback_en && $stable(cts_n))[*3] |-> cts_status == !cts_n)
        else $error("clear to send status not inverse of pin");

    a_cts_loopback: assert property (
        sel_rd == SEL_MODEM && loopback_en |=> bus_rdata[`MODEM_CTS_BIT] == $past(rts_ctrl))
        else $error("loopback clear to send does not follow request to send");

    a_spare_rw: assert property (
        (sel_wr == SEL_SPARE) ##1 (sel_rd == SEL_SPARE)
            |=> bus_rdata == {8'h00, $past(bus_req.wdata[7:0], 2)})
        else $error("spare byte did not return written value");

    a_modem_rsvd: assert property (
        sel_rd == SEL_MODEM |=> bus_rdata[15:5] == 11'h000 && bus_rdata[3:0] == 4'h0)
        else $error("reserved modem status bits not zero");

    // Read path: every answer stands one cycle and carries only documented fields

    a_rdata_idle: assert property (
        !bus_req.rd
            |=> bus_rdata == `RDATA_IDLE)
        else $error("read data not idle without a read");

    a_rxbuf_read: assert property (
        sel_rd == SEL_RXBUF
            |=> bus_rdata == {8'h00, $past(rx_buffer_reg)})
        else $error("receive buffer read returned wrong data");

    a_line_upper: assert property (
        sel_rd == SEL_LINE
            |=> bus_rdata[15:2] == 14'h0000)
        else $error("line status upper bits not zero");

    a_spare_upper: assert property (
        sel_rd == SEL_SPARE
            |=> bus_rdata[15:8] == 8'h00)
        else $error("reserved spare register bits not zero");

    a_da_buf_view: assert property (
        rd_line && !fifo_mode
            |=> bus_rdata[`LINE_DA_BIT] == $past(ready_reg))
        else $error("data available does not match holding buffer");

    a_cts_read_pin: assert property (
        sel_rd == SEL_MODEM && !loopback_en
            |=> bus_rdata[`MODEM_CTS_BIT] == !$past(cts_sync_reg))
        else $error("clear to send read not inverse of synchronised pin");

    // Receive side: the buffer and the FIFO push follow the mode

    a_buf_hold: assert property (
        !rx_char.valid
            |=> $stable(rx_buffer_reg))
        else $error("holding buffer changed without a character");

    a_fifo_no_buf: assert property (
        rx_char.valid && fifo_mode
            |=> $stable(rx_buffer_reg))
        else $error("holding buffer written in FIFO mode");

    a_push_fifo_ok: assert property (
        rx_char.valid && fifo_mode && !fifo_full
            |=> fifo_push.valid && fifo_push.data == $past(rx_char.data))
        else $error("character not pushed into FIFO with room");

    a_push_quiet: assert property (
        !(rx_char.valid && fifo_mode)
            |=> !fifo_push.valid)
        else $error("FIFO push without a FIFO mode arrival");

    a_ready_sticky: assert property (
        ready_reg && !fifo_mode && !rd_rxbuf
            |=> ready_reg)
        else $error("data available dropped without a buffer read");

    a_ready_fifo_clear: assert property (
        fifo_mode
            |=> !ready_reg)
        else $error("holding flag kept in FIFO mode");

    // Overrun: only a real event raises it

    a_ovr_quiet: assert property (
        !overrun_reg && !ovr_event
            |=> !overrun_reg)
        else $error("overrun raised without an event");

    a_ovr_read_first: assert property (
        rx_char.valid && !fifo_mode && rd_rxbuf && !overrun_reg
            |=> !overrun_reg)
        else $error("overrun raised although the buffer was read");

    // Spare byte keeps what software wrote and nothing else

    a_spare_write: assert property (
        sel_wr == SEL_SPARE
            |=> spare_reg == $past(bus_req.wdata[7:0]))
        else $error("spare byte did not take the write");

    a_spare_hold: assert property (
        sel_wr != SEL_SPARE
            |=> $stable(spare_reg))
        else $error("spare byte changed without a write");

    // Main scenarios that the bench is expected to reach
    c_nonfifo_overrun: cover property (
        rx_char.valid && !fifo_mode ##[1:50] rx_char.valid && !fifo_mode && overrun_reg);
    c_fifo_overrun: cover property (rx_char.valid && fifo_mode && fifo_full);
    c_loopback_read: cover property (loopback_en && sel_rd == SEL_MODEM);
    c_overrun_cleared: cover property (overrun_reg ##1 rd_line ##1 !overrun_reg);
    c_fifo_drained: cover property (fifo_mode && rx_data_available ##1 !rx_data_available);

endmodule

// file: uart_rx_status_params.svh
// Register offsets, field positions and reset values of the receive status block
`ifndef UART_RX_STATUS_PARAMS_SVH
`define UART_RX_STATUS_PARAMS_SVH

`define ADDR_RX_BUFFER 32'h5000_1000
`define ADDR_LINE_STATUS 32'h5000_1014
`define ADDR_MODEM_STATUS 32'h5000_1018
`define ADDR_SPARE_STORAGE 32'h5000_101C

`define LINE_DA_BIT 0
`define LINE_OVR_BIT 1
`define MODEM_CTS_BIT 4
`define SPARE_MSB 7

`define RX_BUFFER_RESET 8'h00
`define SPARE_RESET 8'h00
`define CTS_N_SYNC_RESET 1'b0
`define RDATA_IDLE 16'h0000

`endif

// file: uart_rx_status_pkg.sv
// Types shared by the receive status block
package uart_rx_status_pkg;

    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_RXBUF = 3'b001,
        SEL_LINE = 3'b010,
        SEL_MODEM = 3'b011,
        SEL_SPARE = 3'b100
    } reg_sel_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_char_s;

endpackage
